// >>> logic/mbrtc_defs.svh
// constants for the muxed-bus clock/ram host port: locations, fields, resets, apb map
`ifndef MBRTC_DEFS_SVH
`define MBRTC_DEFS_SVH

// ===========================================================================
// location map (64 bytes)
`define MBRTC_NUM_LOCS 64
`define MBRTC_LOC_SECONDS 6'h00
`define MBRTC_LOC_RATE_CTRL 6'h0a
`define MBRTC_LOC_MODE_CTRL 6'h0b
`define MBRTC_LOC_IRQ_FLAGS 6'h0c
`define MBRTC_LOC_RAM_VALID 6'h0d

// ===========================================================================
// field positions
`define MBRTC_RATE_RO_BIT 7
`define MBRTC_TB_FIELD_HI 6
`define MBRTC_TB_FIELD_LO 4
`define MBRTC_TB_4M 3'h0
`define MBRTC_TB_1M 3'h1
`define MBRTC_TB_32K 3'h2
`define MBRTC_SEC_RO_BIT 7
`define MBRTC_DST_BIT 0
`define MBRTC_VRT_BIT 7

// ===========================================================================
// reset values
`define MBRTC_LOC_RESET 8'h00
`define MBRTC_CTRL_RESET 32'h0000_0001

// ===========================================================================
// apb map (byte addresses)
`define MBRTC_APB_AW 12
`define MBRTC_APB_CTRL 12'h000
`define MBRTC_APB_STATUS 12'h004
`define MBRTC_CTRL_EN_BIT 0
`define MBRTC_ST_PROTO_BIT 0
`define MBRTC_ST_VRT_BIT 1
`define MBRTC_ST_TB_LO 2
`define MBRTC_ST_TB_HI 4
`define MBRTC_ST_TBOK_BIT 5

`endif

// >>> logic/mbrtc_pkg.sv
// types shared by the muxed-bus clock/ram host port
package mbrtc_pkg;

    // detected host protocol
    typedef enum logic {
        MBRTC_PROTO_STROBE,
        MBRTC_PROTO_RDWR
    } mbrtc_proto_t;

    // decoded time base selection
    typedef enum logic [1:0] {
        MBRTC_TB_4M194,
        MBRTC_TB_1M048,
        MBRTC_TB_32K768,
        MBRTC_TB_NONE
    } mbrtc_tb_t;

    // the muxed bus control and address/data pins, input side
    typedef struct packed {
        logic as;
        logic ds;
        logic rw;
        logic ce_n;
        logic [7:0] ad;
    } mbrtc_pins_t;

endpackage

// >>> logic/mbrtc_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module mbrtc_sync #(
    parameter int W = 12,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and filtered levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    // ===========================================================================
    // one chain per bit; stage one feeds stage two only
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic filt_reg;
            // a change counts only once stages two and three agree
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_reg <= RST[i];
                    s2_reg <= RST[i];
                    s3_reg <= RST[i];
                    filt_reg <= RST[i];
                end else begin
                    s1_reg <= pin_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        filt_reg <= s3_reg;
                    end
                end
            end
            assign level_out[i] = filt_reg;
        end
    endgenerate

endmodule

// >>> logic/mbrtc_port.sv
// muxed-bus host port and 64-byte location map of the clock/ram device
`timescale 1ns/1ps
`include "mbrtc_defs.svh"

// Behaviour
// - latch data strobe level while address strobe high
// - 64 locations: 10 time, 4 control, 50 ram
// - flag and ram-valid registers ignore writes
// - rate control top bit is read-only
// - seconds top bit always reads zero
// - reading ram-valid register sets valid flag
// - time base chosen by rate control field
// - no daylight saving: enable bit stays zero
module mbrtc_port
    import mbrtc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MBRTC_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // muxed bus pins
    input wire mbrtc_pins_t pins,
    output logic [7:0] ad_out,
    output logic ad_oe,
    // status toward the rest of the device
    output mbrtc_proto_t host_proto,
    output mbrtc_tb_t time_base_sel
);

    // ===========================================================================
    // pin synchronisers
    mbrtc_pins_t pin_s;
    logic [11:0] pin_lvl;
    // idle pins: strobe low, r/w high, chip enable off
    mbrtc_sync #(
        .W(12),
        .RST(12'h300)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pins),
        .level_out(pin_lvl)
    );
    assign pin_s = pin_lvl;

    // ===========================================================================
    // state
    logic [7:0] mem_reg [0:`MBRTC_NUM_LOCS-1];
    mbrtc_proto_t proto_reg;
    logic [5:0] addr_reg;
    logic as_q_reg;
    logic ds_q_reg;
    logic rw_q_reg;
    logic rd_q_reg;
    logic vrt_reg;
    logic [7:0] rd_data_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] prdata_reg;
    logic port_en;
    logic as_fall;
    logic rd_phase;
    logic rd_start;
    logic wr_evt;
    logic [7:0] wr_byte;
    logic [7:0] rd_view;
    logic [2:0] tb_field;

    assign port_en = ctrl_reg[`MBRTC_CTRL_EN_BIT];
    assign as_fall = as_q_reg && !pin_s.as;

    // ===========================================================================
    // protocol detection, level held while address strobe is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proto_reg <= MBRTC_PROTO_STROBE;
        end else if (pin_s.as) begin
            // the host keeps the strobe level fixed through the pulse
            proto_reg <= pin_s.ds ? MBRTC_PROTO_RDWR : MBRTC_PROTO_STROBE;
        end
    end
    assign host_proto = proto_reg;

    // ===========================================================================
    // address capture and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= 6'h00;
        end else if (as_fall) begin
            addr_reg <= pin_s.ad[5:0];
        end
    end

    // delayed copies for edge detection on strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            as_q_reg <= 1'b0;
            ds_q_reg <= 1'b0;
            rw_q_reg <= 1'b1;
            rd_q_reg <= 1'b0;
        end else begin
            as_q_reg <= pin_s.as;
            ds_q_reg <= pin_s.ds;
            rw_q_reg <= pin_s.rw;
            rd_q_reg <= rd_phase;
        end
    end

    // ===========================================================================
    // phase decode per protocol
    // strobe style: read while strobe high and r/w high, write on strobe fall
    // rd/wr style: read while rd low, write on rising edge of wr
    always_comb begin
        if (proto_reg == MBRTC_PROTO_STROBE) begin
            rd_phase = pin_s.ds && pin_s.rw && !pin_s.as;
            wr_evt = ds_q_reg && !pin_s.ds && !rw_q_reg;
        end else begin
            rd_phase = !pin_s.ds && !pin_s.as;
            wr_evt = !rw_q_reg && pin_s.rw;
        end
        // chip enable gates the read and write phases, not address capture or protocol detection; the apb control can take the port off
        rd_phase = rd_phase && !pin_s.ce_n && port_en;
        wr_evt = wr_evt && !pin_s.ce_n && port_en;
    end
    assign rd_start = rd_phase && !rd_q_reg;

    // ===========================================================================
    // write shaping per location
    always_comb begin
        case (addr_reg)
            `MBRTC_LOC_RATE_CTRL: begin
                wr_byte = {mem_reg[`MBRTC_LOC_RATE_CTRL][`MBRTC_RATE_RO_BIT],
                           pin_s.ad[6:0]};
            end
            `MBRTC_LOC_MODE_CTRL: begin
                // this variant has no daylight saving, enable pinned low
                wr_byte = {pin_s.ad[7:1], 1'b0};
            end
            `MBRTC_LOC_IRQ_FLAGS, `MBRTC_LOC_RAM_VALID: begin
                wr_byte = mem_reg[addr_reg];
            end
            default: begin
                wr_byte = pin_s.ad;
            end
        endcase
    end

    // ===========================================================================
    // location storage, one flop byte per entry
    genvar gi;
    generate
        for (gi = 0; gi < `MBRTC_NUM_LOCS; gi = gi + 1) begin : g_loc
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_reg[gi] <= `MBRTC_LOC_RESET;
                end else if (wr_evt && addr_reg == 6'(gi)) begin
                    mem_reg[gi] <= wr_byte;
                end
            end
        end
    endgenerate

    // ===========================================================================
    // valid-ram-time flag; only a read of the ram-valid register touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vrt_reg <= 1'b0;
        end else if (rd_start && addr_reg == `MBRTC_LOC_RAM_VALID) begin
            vrt_reg <= 1'b1;
        end
    end

    // ===========================================================================
    // read view and read data register
    always_comb begin
        case (addr_reg)
            `MBRTC_LOC_SECONDS: begin
                rd_view = {1'b0, mem_reg[`MBRTC_LOC_SECONDS][6:0]};
            end
            `MBRTC_LOC_RAM_VALID: begin
                rd_view = {vrt_reg, 7'h00};
            end
            default: begin
                rd_view = mem_reg[addr_reg];
            end
        endcase
    end

    // refreshed every cycle so data is ready before the strobe opens the driver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_view;
        end
    end
    assign ad_out = rd_data_reg;
    assign ad_oe = rd_phase;

    // ===========================================================================
    // time base selection from the rate control field
    assign tb_field = mem_reg[`MBRTC_LOC_RATE_CTRL][`MBRTC_TB_FIELD_HI:`MBRTC_TB_FIELD_LO];
    always_comb begin
        case (tb_field)
            `MBRTC_TB_4M: time_base_sel = MBRTC_TB_4M194;
            `MBRTC_TB_1M: time_base_sel = MBRTC_TB_1M048;
            `MBRTC_TB_32K: time_base_sel = MBRTC_TB_32K768;
            default: time_base_sel = MBRTC_TB_NONE;
        endcase
    end

    // ===========================================================================
    // apb slave: read data latched in the setup cycle, answer in first access
    logic apb_setup;
    logic apb_hit;
    assign apb_setup = psel && !penable;
    assign apb_hit = (paddr == `MBRTC_APB_CTRL) || (paddr == `MBRTC_APB_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_hit;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (apb_setup) begin
            case (paddr)
                `MBRTC_APB_CTRL: prdata_reg <= ctrl_reg;
                `MBRTC_APB_STATUS: begin
                    prdata_reg <= {26'h000_0000,
                                   time_base_sel != MBRTC_TB_NONE,
                                   tb_field,
                                   vrt_reg,
                                   proto_reg == MBRTC_PROTO_RDWR};
                end
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // control register; only the enable bit is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `MBRTC_CTRL_RESET;
        end else if (psel && penable && pwrite && paddr == `MBRTC_APB_CTRL) begin
            ctrl_reg <= {31'h0000_0000, pwdata[`MBRTC_CTRL_EN_BIT]};
        end
    end

    // ===========================================================================
    // assertions
    sequence s_as_fall;
        pin_s.as ##1 !pin_s.as;
    endsequence

    sequence s_wr_loc(logic [5:0] loc);
        wr_evt && addr_reg == loc;
    endsequence

    a_proto_latch: assert property (@(posedge pclk) disable iff (!presetn)
        pin_s.as |=> proto_reg == ($past(pin_s.ds) ? MBRTC_PROTO_RDWR : MBRTC_PROTO_STROBE))
        else $error("protocol not taken from strobe level");

    a_addr_capture: assert property (@(posedge pclk) disable iff (!presetn)
        s_as_fall |=> addr_reg == $past(pin_s.ad[5:0]))
        else $error("address not captured at strobe fall");

    a_ram_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_evt && addr_reg > `MBRTC_LOC_RAM_VALID) |=> mem_reg[$past(addr_reg)] == $past(pin_s.ad))
        else $error("location write lost");

    a_ro_regs: assert property (@(posedge pclk) disable iff (!presetn)
        (s_wr_loc(`MBRTC_LOC_IRQ_FLAGS) or s_wr_loc(`MBRTC_LOC_RAM_VALID))
        |=> $stable(mem_reg[`MBRTC_LOC_IRQ_FLAGS]) && $stable(vrt_reg))
        else $error("read-only register changed by write");

    a_rate_msb: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_loc(`MBRTC_LOC_RATE_CTRL) |=>
        mem_reg[`MBRTC_LOC_RATE_CTRL] == {$past(mem_reg[`MBRTC_LOC_RATE_CTRL][7]),
                                           $past(pin_s.ad[6:0])})
        else $error("rate control write shaped wrongly");

    a_sec_msb: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(addr_reg) == `MBRTC_LOC_SECONDS) |-> !rd_data_reg[7])
        else $error("seconds top bit read as one");

    a_vrt_set: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_start && addr_reg == `MBRTC_LOC_RAM_VALID) |=> vrt_reg ##1 vrt_reg)
        else $error("valid flag not set by read");

    a_tb_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (tb_field == `MBRTC_TB_32K) |-> time_base_sel == MBRTC_TB_32K768)
        else $error("time base not taken from field");

    a_no_dst: assert property (@(posedge pclk) disable iff (!presetn)
        s_wr_loc(`MBRTC_LOC_MODE_CTRL) |=> !mem_reg[`MBRTC_LOC_MODE_CTRL][`MBRTC_DST_BIT])
        else $error("daylight saving enable accepted");

    a_bus_float: assert property (@(posedge pclk) disable iff (!presetn)
        ad_oe |-> !pin_s.ce_n && !pin_s.as && port_en)
        else $error("bus driven outside read phase");

endmodule

// >>> testbench/mbrtc_host_model.sv
// multiplexed-bus host processor model driving the clock/ram port pins
`timescale 1ns/1ps

module mbrtc_host_model
    import mbrtc_pkg::*;
(
    // clock
    input wire logic pclk,
    // device side of the shared data lines
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    // pins toward the device
    output mbrtc_pins_t pins
);
    logic as_r, ds_r, rw_r, ce_n_r, drv;
    logic [7:0] ad_r;
    logic [7:0] ad_last;
    logic [7:0] ad_w;

    // idle: no strobes, chip not enabled, lines released
    initial begin
        as_r = 1'b0;
        ds_r = 1'b0;
        rw_r = 1'b1;
        ce_n_r = 1'b1;
        drv = 1'b0;
        ad_r = 8'h00;
        ad_last = 8'h00;
    end

    // a released bus shows the inverse of its last level, never a stale copy
    assign ad_w = drv ? ad_r : (ad_oe ? ad_out : ~ad_last);
    assign pins = {as_r, ds_r, rw_r, ce_n_r, ad_w};

    // only a driven level is remembered, so a floating bus holds still
    always @(posedge pclk) begin
        if (drv || ad_oe) begin
            ad_last <= ad_w;
        end
    end

    // ======================================================================
    // bus cycles
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // chip enable follows the strobe pulse, so a change of host style leaves
    // no stray read phase decoded under the previously detected protocol
    task automatic addr_phase(input logic rdwr, input logic [5:0] a);
        ds_r <= rdwr;
        drv <= 1'b1;
        ad_r <= {2'b00, a};
        wait_n(6);
        as_r <= 1'b1;
        wait_n(6);
        as_r <= 1'b0;
        ce_n_r <= 1'b0;
        wait_n(2);
    endtask

    task automatic end_cycle();
        drv <= 1'b0;
        ce_n_r <= 1'b1;
        wait_n(6);
    endtask

    // strobe host writes on data strobe fall, rd/wr host on write strobe rise
    task automatic wr(input logic rdwr, input logic [5:0] a, input logic [7:0] d);
        addr_phase(rdwr, a);
        ad_r <= d;
        rw_r <= 1'b0;
        if (!rdwr) begin
            wait_n(1);
            ds_r <= 1'b1;
        end
        wait_n(6);
        if (rdwr) begin
            rw_r <= 1'b1;
        end else begin
            ds_r <= 1'b0;
        end
        wait_n(6);
        rw_r <= 1'b1;
        end_cycle();
    endtask

    // read phase long enough for the synchronisers plus data delay
    task automatic rd(input logic rdwr, input logic [5:0] a, output logic [7:0] d,
                      output logic oe);
        addr_phase(rdwr, a);
        drv <= 1'b0;
        wait_n(2);
        ds_r <= !rdwr;
        wait_n(8);
        d = ad_w;
        oe = ad_oe;
        ds_r <= rdwr;
        wait_n(6);
        end_cycle();
    endtask
endmodule

// >>> testbench/muxed_bus_rtc_register_map_tb.sv
// self-checking bench for the muxed-bus clock/ram host port
`timescale 1ns/1ps
`include "mbrtc_defs.svh"

module muxed_bus_rtc_register_map_tb import mbrtc_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ad_oe, err, hoe;
    logic [`MBRTC_APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] ad_out, hd;
    mbrtc_pins_t pins;
    mbrtc_proto_t host_proto;
    mbrtc_tb_t time_base_sel;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;

    mbrtc_port mbrtc_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .ad_out(ad_out), .ad_oe(ad_oe), .host_proto(host_proto),
        .time_base_sel(time_base_sel));
    mbrtc_host_model mbrtc_host_model_inst (.pclk(pclk), .ad_out(ad_out), .ad_oe(ad_oe),
        .pins(pins));

    // ======================================================================
    // helpers
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; an extra edge afterwards keeps back-to-back calls clean
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("unexpected pready: expected 1 seen %b", pready);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ======================================================================
    // scenarios
    task automatic t_reset();
        apb(1'b0, `MBRTC_APB_CTRL, 32'h0);
        check("ctrl", `MBRTC_CTRL_RESET, rdat);
        apb(1'b0, `MBRTC_APB_STATUS, 32'h0);
        check("status", 32'h0000_0020, rdat);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rdat);
        check("tb sel", MBRTC_TB_4M194, time_base_sel);
    endtask

    // read data refreshes every cycle, so the setting read already shows the flag
    task automatic t_vrt();
        apb(1'b0, `MBRTC_APB_STATUS, 32'h0);
        check("vrt before", 32'h0, rdat[`MBRTC_ST_VRT_BIT]);
        mbrtc_host_model_inst.rd(1'b1, `MBRTC_LOC_RAM_VALID, hd, hoe);
        check("ram valid first", 32'h80, hd);
        apb(1'b0, `MBRTC_APB_STATUS, 32'h0);
        check("vrt after", 32'h1, rdat[`MBRTC_ST_VRT_BIT]);
        mbrtc_host_model_inst.wr(1'b0, `MBRTC_LOC_RAM_VALID, 8'h00);
        mbrtc_host_model_inst.rd(1'b0, `MBRTC_LOC_RAM_VALID, hd, hoe);
        check("ram valid next", 32'h80, hd);
    endtask

    task automatic t_timebase();
        for (int c = 0; c < 4; c++) begin
            mbrtc_host_model_inst.wr(c[0], `MBRTC_LOC_RATE_CTRL, {1'b0, c[2:0], 4'h5});
            check("tb sel", (c < 3) ? c : 32'(MBRTC_TB_NONE), time_base_sel);
            apb(1'b0, `MBRTC_APB_STATUS, 32'h0);
            check("tb status", {c < 3, c[2:0]}, rdat[5:2]);
        end
    endtask

    // write all first, then read back with the other host style
    task automatic t_ram();
        logic [5:0] locs [4] = '{6'h0e, 6'h3f, 6'h01, 6'h09};
        foreach (locs[i]) begin
            mbrtc_host_model_inst.wr(1'b0, locs[i], {2'b10, locs[i]});
            check("proto strobe", MBRTC_PROTO_STROBE, host_proto);
        end
        foreach (locs[i]) begin
            mbrtc_host_model_inst.rd(1'b1, locs[i], hd, hoe);
            check("proto rdwr", MBRTC_PROTO_RDWR, host_proto);
            check("ram data", {2'b10, locs[i]}, hd);
            check("drive in read", 32'h1, hoe);
            check("drive after read", 32'h0, ad_oe);
        end
    endtask

    task automatic t_readonly();
        logic [5:0] loc [5] = '{`MBRTC_LOC_IRQ_FLAGS, `MBRTC_LOC_RAM_VALID,
            `MBRTC_LOC_RATE_CTRL, `MBRTC_LOC_SECONDS, `MBRTC_LOC_MODE_CTRL};
        logic [7:0] exp [5] = '{8'h00, 8'h80, 8'h7f, 8'h7f, 8'hfe};
        foreach (loc[i]) begin
            mbrtc_host_model_inst.wr(1'b1, loc[i], 8'hff);
            mbrtc_host_model_inst.rd(1'b0, loc[i], hd, hoe);
            check("protected bits", exp[i], hd);
        end
    endtask

    // port switched off: no drive, writes lost
    task automatic t_disable();
        apb(1'b1, `MBRTC_APB_CTRL, 32'h0);
        mbrtc_host_model_inst.wr(1'b0, 6'h20, 8'h33);
        mbrtc_host_model_inst.rd(1'b0, 6'h20, hd, hoe);
        check("drive when off", 32'h0, hoe);
        apb(1'b1, `MBRTC_APB_CTRL, 32'h1);
        mbrtc_host_model_inst.rd(1'b1, 6'h20, hd, hoe);
        check("write while off", 32'h0, hd);
    endtask

    // ======================================================================
    // clock, reset, sequence and watchdog
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_vrt();
        t_timebase();
        t_ram();
        t_readonly();
        t_disable();
        print_verdict();
    end

    // whole run needs roughly 1000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            print_verdict();
        end
    end
endmodule
